// >>> src/gpm_pkg.sv
// Function
// - Pins without a listed default, other than Port B pins 3..2, come out of reset as plain I/O, undriven, with all selects, enables, pulls and codes zero.
// - A pin's input reaches its peripheral only with alternate select, digital enable and a nonzero code all set; pad drive needs select alone.
// - The reset pin resetn restores every pin's select, enable, pull and code defaults.
// - Port A pins 1..0 reset to the UART: select and enable set, no pulls, code 0x1.
// - Port A pins 5..2 reset to the first serial port: select and enable set, no pulls, code 0x1.
// - Port C pins 3..0 reset to debug: select, enable and pull-up set, no pull-down, code 0x3.
// - Seven identical ports A to G, each with its own configuration and data.
// - A software output can change every clock on successive data writes.
// - Each pin's interrupt is edge (rising, falling, both) or level (high, low), gated by a mask.
// - Data accesses use address bits 9..2 as a bit mask for writes and reads.
// - A latched edge is cleared only by writing one to its bit in the clear register.
`default_nettype none
package gpm_pkg;
    localparam int NPORT = 7;
    localparam int NPIN  = 8;
    typedef logic [6:0][7:0]  gpm_byte_t;
    typedef logic [6:0][31:0] gpm_word_t;
    // Offsets within a port; bits 14..12 of the address pick the port
    localparam logic [11:0] OFS_DIR   = 12'h400;
    localparam logic [11:0] OFS_IS    = 12'h404;
    localparam logic [11:0] OFS_IBE   = 12'h408;
    localparam logic [11:0] OFS_IEV   = 12'h40c;
    localparam logic [11:0] OFS_IM    = 12'h410;
    localparam logic [11:0] OFS_RIS   = 12'h414;
    localparam logic [11:0] OFS_MIS   = 12'h418;
    localparam logic [11:0] OFS_ICR   = 12'h41c;
    localparam logic [11:0] OFS_AFSEL = 12'h420;
    localparam logic [11:0] OFS_PUR   = 12'h510;
    localparam logic [11:0] OFS_PDR   = 12'h514;
    localparam logic [11:0] OFS_DEN   = 12'h51c;
    localparam logic [11:0] OFS_PCTL  = 12'h52c;
    // Reset defaults, port G first
    localparam gpm_byte_t AFSEL_RST = {8'h00, 8'h00, 8'h00, 8'h00,
                                       8'h0f, 8'h0c, 8'h3f};
    localparam gpm_byte_t DEN_RST   = {8'h00, 8'h00, 8'h00, 8'h00,
                                       8'h0f, 8'h0c, 8'h3f};
    localparam gpm_byte_t PUR_RST   = {8'h00, 8'h00, 8'h00, 8'h00,
                                       8'h0f, 8'h00, 8'h00};
    localparam gpm_word_t PCTL_RST  = {32'h0, 32'h0, 32'h0, 32'h0,
                                       32'h00003333, 32'h00001100,
                                       32'h00111111};
endpackage
`default_nettype wire

// >>> src/gpm_top.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_top (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    // Register port
    input  wire logic [14:0]   bus_addr,
    input  wire logic [31:0]   bus_wdata,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    output logic      [31:0]   bus_rdata,
    // Pads
    input  wire logic [55:0]   pad_in,
    output logic      [55:0]   pad_out,
    output logic      [55:0]   pad_oe,
    output logic      [55:0]   pad_pu,
    output logic      [55:0]   pad_pd,
    output logic      [55:0]   pad_den,
    // Peripherals
    input  wire logic [55:0]   periph_out,
    input  wire logic [55:0]   periph_oe,
    output logic      [55:0]   periph_in,
    output logic      [55:0]   periph_conn,
    output logic      [223:0]  pin_function_code,
    // Per-port interrupt lines
    output logic      [6:0]    port_irq
);
    // Connection: select, enable and a nonzero code per pin
    function automatic logic [7:0] fn_conn(input logic [7:0]  af,
                                           input logic [7:0]  en,
                                           input logic [31:0] code);
        logic [7:0] c;
        c = '0;
        for (int i = 0; i < 8; i++)
            c[i] = af[i] & en[i] & (code[4*i +: 4] != 4'h0);
        return c;
    endfunction

    gpm_pkg::gpm_byte_t data_q, dir_q, afsel_q, den_q, pur_q, pdr_q;
    gpm_pkg::gpm_byte_t is_q, ibe_q, iev_q, im_q, edge_q;
    gpm_pkg::gpm_byte_t next_data, next_dir, next_afsel, next_den;
    gpm_pkg::gpm_byte_t next_pur, next_pdr, next_is, next_ibe;
    gpm_pkg::gpm_byte_t next_iev, next_im, next_edge;
    gpm_pkg::gpm_byte_t s1, s2, s3, ris, mis, rd_val, ev, conn;
    gpm_pkg::gpm_word_t pctl_q, next_pctl;
    logic [31:0] next_rdata;
    logic [2:0]  ps;
    logic [11:0] off;
    logic        port_ok;
    logic        is_data;
    logic        wr_ok;

    assign ps      = bus_addr[14:12];
    assign off     = bus_addr[11:0];
    assign port_ok = (ps != 3'h7);
    assign is_data = (off[11:10] == 2'b00);
    assign wr_ok   = bus_wr & port_ok;

    // Pin status and event detection, one port at a time
    always_comb
    begin
        for (int p = 0; p < gpm_pkg::NPORT; p++)
        begin
            // Mode bits act per pin; a whole-byte select would mix modes
            ev[p]     = ~is_q[p] & ((ibe_q[p] & (s2[p] ^ s3[p]))
                        | (~ibe_q[p] & iev_q[p] & s2[p] & ~s3[p])
                        | (~ibe_q[p] & ~iev_q[p] & ~s2[p] & s3[p]));
            ris[p]    = (is_q[p] & ~(iev_q[p] ^ s2[p]))
                        | (~is_q[p] & edge_q[p]);
            mis[p]    = ris[p] & im_q[p];
            rd_val[p] = (dir_q[p] & data_q[p]) | (~dir_q[p] & s2[p]);
            conn[p]   = fn_conn(afsel_q[p], den_q[p], pctl_q[p]);
            port_irq[p] = |mis[p];
        end
    end

    // Register writes; each port decodes its own slot
    always_comb
    begin
        next_data  = data_q;
        next_dir   = dir_q;
        next_afsel = afsel_q;
        next_den   = den_q;
        next_pur   = pur_q;
        next_pdr   = pdr_q;
        next_is    = is_q;
        next_ibe   = ibe_q;
        next_iev   = iev_q;
        next_im    = im_q;
        next_pctl  = pctl_q;
        next_edge  = edge_q;
        for (int p = 0; p < gpm_pkg::NPORT; p++)
        begin
            if (wr_ok && ps == 3'(p))
            begin
                if (is_data)
                    next_data[p] = (data_q[p] & ~off[9:2])
                                 | (bus_wdata[7:0] & off[9:2]);
                else if (off == gpm_pkg::OFS_ICR)
                    next_edge[p] = edge_q[p] & ~bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_DIR)
                    next_dir[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_IS)
                    next_is[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_IBE)
                    next_ibe[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_IEV)
                    next_iev[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_IM)
                    next_im[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_AFSEL)
                    next_afsel[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_PUR)
                    next_pur[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_PDR)
                    next_pdr[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_DEN)
                    next_den[p] = bus_wdata[7:0];
                else if (off == gpm_pkg::OFS_PCTL)
                    next_pctl[p] = bus_wdata;
            end
            // A new edge wins over a clear in the same cycle
            next_edge[p] = next_edge[p] | ev[p];
        end
    end

    // Read data, returned in the cycle after the strobe
    always_comb
    begin
        next_rdata = '0;
        if (bus_rd && port_ok)
        begin
            if (is_data)
                next_rdata[7:0] = rd_val[ps] & off[9:2];
            else
                unique case (off)
                    gpm_pkg::OFS_DIR:   next_rdata[7:0] = dir_q[ps];
                    gpm_pkg::OFS_IS:    next_rdata[7:0] = is_q[ps];
                    gpm_pkg::OFS_IBE:   next_rdata[7:0] = ibe_q[ps];
                    gpm_pkg::OFS_IEV:   next_rdata[7:0] = iev_q[ps];
                    gpm_pkg::OFS_IM:    next_rdata[7:0] = im_q[ps];
                    gpm_pkg::OFS_RIS:   next_rdata[7:0] = ris[ps];
                    gpm_pkg::OFS_MIS:   next_rdata[7:0] = mis[ps];
                    gpm_pkg::OFS_AFSEL: next_rdata[7:0] = afsel_q[ps];
                    gpm_pkg::OFS_PUR:   next_rdata[7:0] = pur_q[ps];
                    gpm_pkg::OFS_PDR:   next_rdata[7:0] = pdr_q[ps];
                    gpm_pkg::OFS_DEN:   next_rdata[7:0] = den_q[ps];
                    gpm_pkg::OFS_PCTL:  next_rdata = pctl_q[ps];
                    default:            next_rdata = '0;
                endcase
        end
    end

    // Pads are asynchronous to sys_clk: two stages before use
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= pad_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_q    <= '0;
            dir_q     <= '0;
            pdr_q     <= '0;
            is_q      <= '0;
            ibe_q     <= '0;
            iev_q     <= '0;
            im_q      <= '0;
            edge_q    <= '0;
            afsel_q   <= gpm_pkg::AFSEL_RST;
            den_q     <= gpm_pkg::DEN_RST;
            pur_q     <= gpm_pkg::PUR_RST;
            pctl_q    <= gpm_pkg::PCTL_RST;
            bus_rdata <= '0;
        end
        else
        begin
            data_q    <= next_data;
            dir_q     <= next_dir;
            pdr_q     <= next_pdr;
            is_q      <= next_is;
            ibe_q     <= next_ibe;
            iev_q     <= next_iev;
            im_q      <= next_im;
            edge_q    <= next_edge;
            afsel_q   <= next_afsel;
            den_q     <= next_den;
            pur_q     <= next_pur;
            pctl_q    <= next_pctl;
            bus_rdata <= next_rdata;
        end
    end

    // Peripheral takes over pad_out and pad_oe under alternate select; pulls and digital enable stay with the registers
    assign pad_out = (afsel_q & periph_out) | (~afsel_q & data_q);
    assign pad_oe  = (afsel_q & periph_oe) | (~afsel_q & dir_q);
    assign pad_pu  = pur_q;
    assign pad_pd  = pdr_q;
    assign pad_den = den_q;
    assign periph_conn = conn;
    assign periph_in   = conn & s2;
    assign pin_function_code = pctl_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_rst_plain;
        $rose(resetn) |-> dir_q == '0 && pdr_q == '0 && data_q == '0;
    endproperty
    a_rst_plain: assert property (p_rst_plain) else $error("reset io");
    property p_rst_uart;
        $rose(resetn) |-> pctl_q[0][7:0] == 8'h11 && afsel_q[0][1:0] == 2'h3;
    endproperty
    a_rst_uart: assert property (p_rst_uart) else $error("uart default");
    property p_rst_ser;
        $rose(resetn) |-> pctl_q[0][23:8] == 16'h1111 && den_q[0][5:2] == 4'hf;
    endproperty
    a_rst_ser: assert property (p_rst_ser) else $error("serial default");
    property p_rst_i2c;
        $rose(resetn) |-> pctl_q[1] == 32'h00001100 && afsel_q[1] == 8'h0c;
    endproperty
    a_rst_i2c: assert property (p_rst_i2c) else $error("i2c default");
    property p_rst_dbg;
        $rose(resetn) |-> pctl_q[2] == 32'h00003333 && pur_q[2] == 8'h0f;
    endproperty
    a_rst_dbg: assert property (p_rst_dbg) else $error("debug default");
    property p_conn;
        (periph_in & ~periph_conn) == '0 && (periph_conn & ~pad_den) == '0;
    endproperty
    a_conn: assert property (p_conn) else $error("bad connection");
    property p_takeover;
        afsel_q[0][0] |-> pad_out[0] == periph_out[0] && pad_oe[0] == periph_oe[0];
    endproperty
    a_takeover: assert property (p_takeover) else $error("alt drive");
    property p_toggle;
        bus_wr && bus_addr[14:10] == 5'h0 && bus_addr[2] && !afsel_q[0][0]
            |=> pad_out[0] == $past(bus_wdata[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle");
    property p_rd_mask;
        bus_rd && port_ok && is_data
            |=> (bus_rdata & ~{24'h0, $past(off[9:2])}) == 32'h0;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("read mask");
    property p_wr_mask;
        bus_wr && bus_addr[14:10] == 5'h0
            |=> (data_q[0] & ~$past(bus_addr[9:2]))
                == ($past(data_q[0]) & ~$past(bus_addr[9:2]));
    endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("write mask");
    property p_hold;
        edge_q[5][0] && !(wr_ok && ps == 3'h5 && off == gpm_pkg::OFS_ICR
            && bus_wdata[0]) |=> edge_q[5][0];
    endproperty
    a_hold: assert property (p_hold) else $error("edge lost");
    property p_level;
        im_q[5][0] && is_q[5][0] && iev_q[5][0] && s2[5][0] |-> port_irq[5];
    endproperty
    a_level: assert property (p_level) else $error("level irq");
    c_toggle: cover property (bus_wr && is_data ##2 bus_wr && is_data);
    c_edge: cover property ($rose(edge_q[5][0]) ##[1:20] !edge_q[5][0]);
    c_alt: cover property ($fell(afsel_q[0][0]));
endmodule
`default_nettype wire

// >>> sim/gpm_partner.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_partner (
    // Clock
    input  wire logic          sys_clk,
    // Pad drive from the block
    input  wire logic [55:0]   pad_out,
    input  wire logic [55:0]   pad_oe,
    input  wire logic [55:0]   pad_pu,
    input  wire logic [55:0]   pad_pd,
    // Outside drivers steered by the bench
    input  wire logic [55:0]   ext_lvl,
    input  wire logic [55:0]   ext_drv,
    // Toward the block
    output logic      [55:0]   pad_in,
    output logic      [55:0]   periph_out,
    output logic      [55:0]   periph_oe
);
    logic [55:0] flip = 56'h0;
    // A floating pad wanders, so nothing may lean on its last level
    always_comb
        for (int i = 0; i < 56; i++)
            pad_in[i] = ext_drv[i] ? ext_lvl[i] : pad_oe[i] ? pad_out[i] :
                pad_pu[i] ? 1'b1 : pad_pd[i] ? 1'b0 : flip[i];
    // Peripherals change their drive every cycle
    always_ff @(posedge sys_clk)
    begin
        flip       <= ~flip;
        periph_out <= 56'({$urandom, $urandom});
        periph_oe  <= 56'({$urandom, $urandom});
    end
endmodule
`default_nettype wire

// >>> sim/test_gpm_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_gpm_top;
    logic          sys_clk = 1'b0;
    logic          resetn = 1'b0;
    logic [14:0]   bus_addr = 15'h0;
    logic [31:0]   bus_wdata = 32'h0;
    logic          bus_wr = 1'b0;
    logic          bus_rd = 1'b0;
    logic [55:0]   ext_lvl = 56'h0;
    logic [55:0]   ext_drv = 56'h0;
    logic [31:0]   bus_rdata;
    logic [55:0]   pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_den;
    logic [55:0]   periph_out, periph_oe, periph_in, periph_conn;
    logic [223:0]  pin_function_code;
    logic [6:0]    port_irq;
    logic [31:0]   exp_q[$];
    logic          rd_q = 1'b0;
    int            miscompares = 0;
    int            total_checks = 0;

    gpm_top gpm_top_i (.sys_clk, .resetn, .bus_addr, .bus_wdata, .bus_wr,
        .bus_rd, .bus_rdata, .pad_in, .pad_out, .pad_oe, .pad_pu, .pad_pd,
        .pad_den, .periph_out, .periph_oe, .periph_in, .periph_conn,
        .pin_function_code, .port_irq);
    gpm_partner gpm_partner_i (.sys_clk, .pad_out, .pad_oe, .pad_pu,
        .pad_pd, .ext_lvl, .ext_drv, .pad_in, .periph_out, .periph_oe);

    initial
        forever #4 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Two cycles per access keeps strobes from being set twice at one edge
    task automatic wr(input int p, input logic [11:0] ofs,
                      input logic [31:0] d);
        bus_addr  <= {p[2:0], ofs};
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge sys_clk);
        bus_wr    <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input int p, input logic [11:0] ofs,
                      input logic [31:0] e);
        exp_q.push_back(e);
        bus_addr <= {p[2:0], ofs};
        bus_rd   <= 1'b1;
        @(posedge sys_clk);
        bus_rd   <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (rd_q)
            chk("bus_rdata", bus_rdata, exp_q.pop_front());
        else if (resetn)
            chk("rdata_idle", bus_rdata, 32'h0);
        rd_q <= bus_rd;
    end

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
    endtask

    task automatic chk_defaults();
        logic [7:0]  a;
        logic [31:0] c;
        for (int p = 0; p < 7; p++)
        begin
            a = p == 0 ? 8'h3f : p == 1 ? 8'h0c : p == 2 ? 8'h0f : 8'h00;
            c = p == 0 ? 32'h00111111 : p == 1 ? 32'h00001100 :
                p == 2 ? 32'h00003333 : 32'h0;
            rd(p, gpm_pkg::OFS_AFSEL, 32'(a));
            rd(p, gpm_pkg::OFS_DEN, 32'(a));
            rd(p, gpm_pkg::OFS_PUR, p == 2 ? 32'hf : 32'h0);
            rd(p, gpm_pkg::OFS_PDR, 32'h0);
            rd(p, gpm_pkg::OFS_PCTL, c);
            chk("pin_code", pin_function_code[32*p +: 32], c);
            chk("pad_den", 32'(pad_den[8*p +: 8]), 32'(a));
            chk("pad_pu", 32'(pad_pu[8*p +: 8]), p == 2 ? 32'hf : 32'h0);
            chk("pad_pd", 32'(pad_pd[8*p +: 8]), 32'h0);
        end
        chk("pad_oe", pad_oe[55:24], 32'h0);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        finish_test();
    end

    initial
    begin
        logic [31:0] r;
        logic [7:0]  e;
        logic [4:0]  is, ibe, iev, st;
        // Modes: rising, falling, both, high, low
        is  = 5'b11000;
        ibe = 5'b00100;
        iev = 5'b01001;
        st  = 5'b10010;
        void'($urandom(32'h53e6));
        do_reset();
        chk_defaults();
        $display("defaults done");
        wr(3, gpm_pkg::OFS_DIR, 32'hff);
        wr(3, 12'h098, 32'heb);
        rd(3, 12'h3fc, 32'h22);
        rd(3, 12'h0c4, 32'h20);
        chk("pad_out", 32'(pad_out[31:24]), 32'h22);
        for (int i = 0; i < 6; i++)
        begin
            r = $urandom;
            wr(3, 12'h3fc, r);
            chk("toggle", 32'(pad_out[31:24]), 32'(r[7:0]));
        end
        $display("data done");
        chk("conn", 32'(periph_conn[7:0]), 32'h3f);
        wr(0, gpm_pkg::OFS_DEN, 32'h3e);
        wr(0, gpm_pkg::OFS_PCTL, 32'h00111101);
        chk("conn", 32'(periph_conn[7:0]), 32'h3c);
        @(negedge sys_clk);
        chk("alt_out", 32'(pad_out[5:0]), 32'(periph_out[5:0]));
        chk("alt_oe", 32'(pad_oe[5:0]), 32'(periph_oe[5:0]));
        @(posedge sys_clk);
        wr(0, gpm_pkg::OFS_AFSEL, 32'h3e);
        wr(0, gpm_pkg::OFS_DIR, 32'h01);
        wr(0, 12'h004, 32'h1);
        chk("sw_pin", 32'({pad_oe[0], pad_out[0]}), 32'h3);
        ext_lvl[39:32] <= 8'hff;
        ext_drv[39:32] <= 8'hff;
        wr(4, gpm_pkg::OFS_AFSEL, 32'hff);
        wr(4, gpm_pkg::OFS_DEN, 32'hff);
        repeat (4)
        begin
            r = $urandom;
            wr(4, gpm_pkg::OFS_PCTL, r);
            rd(4, gpm_pkg::OFS_PCTL, r);
            for (int i = 0; i < 8; i++)
                e[i] = r[4*i +: 4] != 4'h0;
            chk("conn_e", 32'(periph_conn[39:32]), 32'(e));
            chk("periph_in", 32'(periph_in[39:32]), 32'(e));
        end
        $display("mux done");
        wr(5, gpm_pkg::OFS_IM, 32'h1);
        ext_drv[40] <= 1'b1;
        for (int m = 0; m < 5; m++)
        begin
            ext_lvl[40] <= st[m];
            wr(5, gpm_pkg::OFS_IS, 32'(is[m]));
            wr(5, gpm_pkg::OFS_IBE, 32'(ibe[m]));
            wr(5, gpm_pkg::OFS_IEV, 32'(iev[m]));
            repeat (4) @(posedge sys_clk);
            wr(5, gpm_pkg::OFS_ICR, 32'h1);
            chk("irq_idle", 32'(port_irq[5]), 32'h0);
            ext_lvl[40] <= ~st[m];
            repeat (5) @(posedge sys_clk);
            chk("irq_set", 32'(port_irq[5]), 32'h1);
            rd(5, gpm_pkg::OFS_MIS, 32'h1);
            if (!is[m])
            begin
                wr(5, gpm_pkg::OFS_ICR, 32'h0);
                chk("irq_held", 32'(port_irq[5]), 32'h1);
                wr(5, gpm_pkg::OFS_ICR, 32'h1);
                chk("irq_clr", 32'(port_irq[5]), 32'h0);
            end
        end
        $display("interrupt done");
        rd(7, gpm_pkg::OFS_DIR, 32'h0);
        rd(3, 12'h600, 32'h0);
        rd(3, gpm_pkg::OFS_ICR, 32'h0);
        wr(3, gpm_pkg::OFS_AFSEL, 32'hff);
        wr(2, gpm_pkg::OFS_PUR, 32'h0);
        wr(1, gpm_pkg::OFS_PCTL, 32'h0);
        do_reset();
        chk_defaults();
        $display("second reset done");
        repeat (2) @(posedge sys_clk);
        finish_test();
    end
endmodule
`default_nettype wire
